// >>> wpf_pkg.sv
// Shared constants and types for the wakeup packet filter
package wpf_pkg;
  localparam int unsigned WPF_CAP_BYTES = 128;
  localparam int unsigned WPF_NUM_RA = 16;
  localparam int unsigned WPF_SYNC_MIN = 6;
  localparam int unsigned WPF_ADDR_COPIES = 16;
  localparam int unsigned WPF_COPY_BYTES = 96;
  localparam logic [15:0] WPF_LLC_MAX_LEN = 16'h05dc;
  localparam logic [47:0] WPF_SNAP_PATTERN = 48'haaaa03000000;
  localparam logic [47:0] WPF_BCAST_ADDR = 48'hffffffffffff;
  localparam logic [7:0] WPF_FF = 8'hff;
  localparam logic [13:0] WPF_TYPE_OFS = 14'h000c;
  localparam logic [13:0] WPF_DA_END = 14'h0006;
  localparam logic [13:0] WPF_VID_END = 14'h0010;
  localparam logic [13:0] WPF_SNAP_END = 14'h0014;
  localparam logic [13:0] WPF_SNAP_VLAN_END = 14'h0018;
  localparam logic [13:0] WPF_LEN_MAX = 14'h3fff;

  // Filter enable bits
  typedef struct packed {
    logic link_change_en;
    logic pattern_en;
    logic broadcast_wake_en;
    logic multicast_wake_en;
    logic exact_wake_en;
  } wpf_filter_ctrl_s;

  // Received-status bits
  typedef struct packed {
    logic link_change_bit;
    logic pattern_rx;
    logic broadcast_rx;
    logic multicast_rx;
    logic exact_rx;
  } wpf_status_s;

  // One received byte with framing
  typedef struct packed {
    logic sof;
    logic eof;
    logic [7:0] data;
  } wpf_byte_s;

  typedef enum logic [1:0] {
    WPF_SEEK_FF = 2'b00,
    WPF_IN_FF = 2'b01,
    WPF_COPIES = 2'b10,
    WPF_FOUND = 2'b11
  } wpf_sync_e;
endpackage

// >>> wpf_pattern_scan.sv
// Wake-pattern sync stream and address-copy search
`timescale 1ns/100ps
module wpf_pattern_scan
  import wpf_pkg::*;
(
  input wire logic clk_i, // Core clock
  input wire logic rst_n_i, // Synchronised reset
  input wire logic valid_i, // Byte strobe
  input wire logic sof_i, // First byte of frame
  input wire logic [7:0] data_i, // Byte value
  input wire logic [47:0] addr_i, // Receive address 0
  output logic found_o // Pattern seen in this frame
);
  wpf_sync_e state_reg;
  logic [2:0] ff_cnt_reg;
  logic [6:0] pos_reg;
  logic [7:0] want;
  logic [2:0] byte_idx;

  // Byte within address, transmitted high byte first
  function automatic logic [7:0] addr_byte(input logic [47:0] a, input logic [2:0] i);
    addr_byte = a[8'(47 - 8 * i) -: 8];
  endfunction

  assign byte_idx = 3'(pos_reg % 7'd6);
  assign want = addr_byte(addr_i, byte_idx);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= WPF_SEEK_FF;
      ff_cnt_reg <= 3'h0;
      pos_reg <= 7'h00;
    end else if (valid_i) begin
      if (sof_i) begin
        state_reg <= (data_i == WPF_FF) ? WPF_IN_FF : WPF_SEEK_FF;
        ff_cnt_reg <= (data_i == WPF_FF) ? 3'h1 : 3'h0;
        pos_reg <= 7'h00;
      end else begin
        case (state_reg)
          WPF_SEEK_FF: begin
            if (data_i == WPF_FF) begin
              state_reg <= WPF_IN_FF;
              ff_cnt_reg <= 3'h1;
            end
          end
          WPF_IN_FF: begin
            if (data_i == WPF_FF) begin
              if (ff_cnt_reg != 3'(WPF_SYNC_MIN)) ff_cnt_reg <= ff_cnt_reg + 3'h1;
            end else if (ff_cnt_reg == 3'(WPF_SYNC_MIN) && data_i == addr_byte(addr_i, 3'h0)) begin
              state_reg <= WPF_COPIES;
              pos_reg <= 7'h01;
            end else begin
              state_reg <= WPF_SEEK_FF;
              ff_cnt_reg <= 3'h0;
            end
          end
          WPF_COPIES: begin
            if (data_i == want) begin
              if (pos_reg == 7'(WPF_COPY_BYTES - 1)) state_reg <= WPF_FOUND;
              pos_reg <= pos_reg + 7'h01;
            end else begin
              // Mismatching byte may itself open a new run
              state_reg <= (data_i == WPF_FF) ? WPF_IN_FF : WPF_SEEK_FF;
              ff_cnt_reg <= (data_i == WPF_FF) ? 3'h1 : 3'h0;
              pos_reg <= 7'h00;
            end
          end
          WPF_FOUND: state_reg <= WPF_FOUND;
          default: state_reg <= WPF_SEEK_FF;
        endcase
      end
    end
  end

  assign found_o = (state_reg == WPF_FOUND);
endmodule

// >>> wpf_wakeup_filter.sv
// Wakeup filter top: frame filters, capture, status and event pin
// Notes on behaviour
// - Wake events come only from pattern packets, filtered packets, link changes.
// - Wakeup packet must pass address filter then some enabled wake filter.
// - Match sets event status; pin drives only with event enable set.
// - Capture first 128 packet bytes into wakeup packet memory.
// - Set a received bit for each filter the packet matched.
// - Record captured packet length in wake packet length.
// - Enabled link up/down sets status, asserts pin, sets link-changed bit.
// - Pin held until status written one or enable written zero.
// - Ignore further packets until all received bits cleared.
// - Ignore link changes until link-changed bit cleared.
// - Each filter matches only while its enable bit is one.
// - Type equal to VLAN EtherType marks tag; look ID up in table.
// - Table miss or VLAN mode off rejects filters comparing the tag.
// - Type up to 1500 needs SNAP pattern for filters checking header.
// - Exact filter wakes on match with any of 16 valid addresses.
// - Multicast filter indexes table by offset-selected upper address bits.
// - Broadcast filter wakes on all-ones destination address.
// - Pattern packets pass filtering; broadcast accepted despite broadcast accept off.
// - Six or more FF bytes, then sixteen copies of address 0.
// - On mismatch in 96 copy bytes, keep scanning for new run.
// - Address 0 loads from nonvolatile store at start-up when enabled.
`timescale 1ns/100ps
module wpf_wakeup_filter
  import wpf_pkg::*;
(
  input wire logic clk_i, // Core clock 40 MHz
  input wire logic rst_n_i, // Async reset, active low
  input wire logic rx_valid_i, // Receive byte strobe
  input wire wpf_byte_s rx_byte_i, // Receive byte with framing
  input wire logic rx_good_i, // Frame good, sampled with eof
  input wire logic addr_filter_pass_i, // Standard address filter verdict
  input wire logic link_up_i, // Link status level from the PHY
  input wire wpf_filter_ctrl_s wake_filter_ctrl_i, // Filter enables
  input wire logic [1:0] multicast_offset_sel_i, // Multicast offset select
  input wire logic broadcast_accept_i, // Broadcast accept
  input wire logic vlan_mode_en_i, // VLAN mode enable
  input wire logic [15:0] vlan_ethertype_i, // Programmed VLAN EtherType
  input wire logic [4095:0] vlan_table_i, // VLAN filter table
  input wire logic [4095:0] mcast_table_i, // Multicast table array
  input wire logic [767:0] rx_addr_i, // Receive addresses 0..15
  input wire logic [15:0] rx_addr_valid_i, // Address valid bits
  input wire logic [47:0] rx_addr0_sw_i, // Software value for address 0
  input wire logic rx_addr0_wr_i, // Software writes address 0
  input wire logic [47:0] nvm_addr0_i, // Address 0 from nonvolatile store
  input wire logic nvm_apm_en_i, // Pattern wake enabled in store
  input wire logic nvm_load_i, // Store load done pulse
  input wire logic pme_en_i, // Event enable bit
  input wire logic pme_status_w1c_i, // Software writes 1 to event status
  input wire wpf_status_s status_clr_i, // Software clear of status bits
  input wire logic [6:0] mem_raddr_i, // Packet memory read address
  output logic [7:0] mem_rdata_o, // Packet memory read data
  output wpf_status_s wake_status_reg_o, // Wake status bits
  output logic [13:0] wake_packet_len_o, // Captured packet length
  output logic pme_status_o, // Event status bit
  output logic pme_n_o, // Event pin, active low
  output logic [47:0] rx_addr0_o // Current address 0
);
  logic rst_s1_reg, rst_n;
  logic link_s1_reg, link_s2_reg, link_prev_reg;
  logic [7:0] mem [WPF_CAP_BYTES];
  logic [13:0] cnt_reg;
  logic [47:0] da_reg;
  logic [15:0] type_reg, type2_reg;
  logic [47:0] snap_reg;
  logic [11:0] vid_reg;
  wpf_status_s status_reg;
  logic pme_status_reg, pme_n_reg;
  logic [13:0] len_reg;
  logic [47:0] addr0_reg;
  logic [7:0] rdata_reg;
  logic [7:0] d;
  logic byte_ok, eof_ok, pkt_busy, link_busy;
  logic is_vlan, vlan_hit, is_llc, snap_ok, is_bcast;
  logic exact_hit, mc_hit, pat_found, pat_ok, any_hit, link_evt;
  wpf_status_s hits;
  logic [11:0] mc_idx;

  // Reset release through two flops
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_s1_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n <= rst_s1_reg;
    end
  end

  // Link level from the PHY is asynchronous
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      link_s1_reg <= 1'b0;
      link_s2_reg <= 1'b0;
      link_prev_reg <= 1'b0;
    end else begin
      link_s1_reg <= link_up_i;
      link_s2_reg <= link_s1_reg;
      link_prev_reg <= link_s2_reg;
    end
  end

  // Address slot of the receive table
  function automatic logic [47:0] ra(input logic [767:0] t, input int i);
    ra = t[48 * i +: 48];
  endfunction

  assign d = rx_byte_i.data;
  assign byte_ok = rx_valid_i;
  assign eof_ok = rx_valid_i && rx_byte_i.eof;

  // VLAN tag detect and ID lookup
  assign is_vlan = (type_reg == vlan_ethertype_i);
  assign vlan_hit = vlan_table_i[vid_reg];
  assign is_llc = is_vlan ? (type2_reg <= WPF_LLC_MAX_LEN) : (type_reg <= WPF_LLC_MAX_LEN);
  assign snap_ok = !is_llc || (snap_reg == WPF_SNAP_PATTERN);

  always_comb begin
    exact_hit = 1'b0;
    for (int i = 0; i < WPF_NUM_RA; i++) begin
      if (rx_addr_valid_i[i] && da_reg == ra(rx_addr_i, i)) exact_hit = 1'b1;
    end
  end

  always_comb begin
    case (multicast_offset_sel_i)
      2'h0: mc_idx = {da_reg[3:0], da_reg[15:8]};
      2'h1: mc_idx = {da_reg[4:0], da_reg[15:9]};
      2'h2: mc_idx = {da_reg[5:0], da_reg[15:10]};
      default: mc_idx = {da_reg[7:0], da_reg[15:12]};
    endcase
  end
  assign mc_hit = mcast_table_i[mc_idx];

  assign is_bcast = (da_reg == WPF_BCAST_ADDR);

  // broadcast passes despite broadcast accept off
  assign pat_ok = addr_filter_pass_i || is_bcast;

  // tag/SNAP outcomes gate only filters that compare them; none of these do
  // Address-based filters also need the standard filter verdict
  assign hits.exact_rx = wake_filter_ctrl_i.exact_wake_en && exact_hit && addr_filter_pass_i;
  assign hits.multicast_rx = wake_filter_ctrl_i.multicast_wake_en && mc_hit && da_reg[40] &&
                             addr_filter_pass_i;
  assign hits.broadcast_rx = wake_filter_ctrl_i.broadcast_wake_en && is_bcast &&
                             addr_filter_pass_i;
  assign hits.pattern_rx = wake_filter_ctrl_i.pattern_en && pat_found && pat_ok;
  assign hits.link_change_bit = 1'b0;

  // address filter or a pattern hit first, then any enabled filter
  assign any_hit = rx_good_i && (addr_filter_pass_i || hits.pattern_rx) &&
                   (hits.exact_rx || hits.multicast_rx || hits.broadcast_rx || hits.pattern_rx);

  // locked while any received bit stands
  assign pkt_busy = status_reg.exact_rx || status_reg.multicast_rx ||
                    status_reg.broadcast_rx || status_reg.pattern_rx;
  assign link_busy = status_reg.link_change_bit;
  assign link_evt = wake_filter_ctrl_i.link_change_en && !link_busy &&
                    (link_s2_reg != link_prev_reg);

  wpf_pattern_scan u_scan (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .valid_i(byte_ok),
    .sof_i(rx_byte_i.sof),
    .data_i(d),
    .addr_i(addr0_reg),
    .found_o(pat_found)
  );

  // Header capture; tags and SNAP only mean something past the address fields
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 14'h0000;
      da_reg <= 48'h000000000000;
      type_reg <= 16'h0000;
      type2_reg <= 16'h0000;
      snap_reg <= 48'h000000000000;
      vid_reg <= 12'h000;
    end else if (byte_ok) begin
      logic [13:0] c;
      c = rx_byte_i.sof ? 14'h0000 : cnt_reg;
      cnt_reg <= (c == WPF_LEN_MAX) ? c : c + 14'h0001;
      if (c < WPF_DA_END) da_reg <= {da_reg[39:0], d};
      if (c >= WPF_TYPE_OFS && c < WPF_TYPE_OFS + 14'h0002) type_reg <= {type_reg[7:0], d};
      if (c >= WPF_TYPE_OFS + 14'h0002 && c < WPF_VID_END) vid_reg <= {vid_reg[3:0], d};
      // Inner type follows the tag control word
      if (c >= WPF_VID_END && c < WPF_VID_END + 14'h0002) type2_reg <= {type2_reg[7:0], d};
      if ((!is_vlan && c >= WPF_TYPE_OFS + 14'h0002 && c < WPF_SNAP_END) ||
          (is_vlan && c >= WPF_VID_END + 14'h0002 && c < WPF_SNAP_VLAN_END))
        snap_reg <= {snap_reg[39:0], d};
    end
  end

  // first 128 bytes, held once a packet wakeup is latched
  always_ff @(posedge clk_i) begin
    if (byte_ok && !pkt_busy) begin
      logic [13:0] c;
      c = rx_byte_i.sof ? 14'h0000 : cnt_reg;
      if (c < 14'(WPF_CAP_BYTES)) mem[c[6:0]] <= d;
    end
  end

  // Memory read port registered
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) rdata_reg <= 8'h00;
    else rdata_reg <= mem[mem_raddr_i];
  end

  // commit at end of good frame
  // one bit per matched filter; sets beat clears
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      status_reg <= '0;
      len_reg <= 14'h0000;
    end else begin
      wpf_status_s nxt;
      nxt = status_reg & ~status_clr_i;
      if (eof_ok && !pkt_busy && any_hit) begin
        nxt = nxt | hits;
        len_reg <= cnt_reg + 14'h0001;
      end
      if (link_evt) nxt.link_change_bit = 1'b1;
      status_reg <= nxt;
    end
  end

  // status always set; pin only when enabled
  // held until w1c or enable cleared
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pme_status_reg <= 1'b0;
      pme_n_reg <= 1'b1;
    end else begin
      logic set;
      set = (eof_ok && !pkt_busy && any_hit) || link_evt;
      if (set) pme_status_reg <= 1'b1;
      else if (pme_status_w1c_i) pme_status_reg <= 1'b0;
      pme_n_reg <= !(pme_en_i && (set || (pme_status_reg && !pme_status_w1c_i)));
    end
  end

  // address 0 from store at start-up, software may override
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) addr0_reg <= 48'h000000000000;
    else if (rx_addr0_wr_i) addr0_reg <= rx_addr0_sw_i;
    else if (nvm_load_i && nvm_apm_en_i) addr0_reg <= nvm_addr0_i;
  end

  assign mem_rdata_o = rdata_reg;
  assign wake_status_reg_o = status_reg;
  assign wake_packet_len_o = len_reg;
  assign pme_status_o = pme_status_reg;
  assign pme_n_o = pme_n_reg;
  assign rx_addr0_o = addr0_reg;
endmodule

// >>> wpf_wakeup_props.sv
// Port checker for the wakeup filter, bound to its top module
`timescale 1ns/100ps
module wpf_wakeup_props
  import wpf_pkg::*;
(
  input wire logic clk_i, // Clock
  input wire logic rst_n_i, // Reset
  input wire logic rx_valid_i, // Byte strobe
  input wire wpf_byte_s rx_byte_i, // Byte
  input wire logic link_up_i, // Link level
  input wire wpf_filter_ctrl_s wake_filter_ctrl_i, // Enables
  input wire logic pme_en_i, // Event enable
  input wire logic pme_status_w1c_i, // Status write
  input wire wpf_status_s status_clr_i, // Clears
  input wire wpf_status_s wake_status_reg_o, // Status
  input wire logic [13:0] wake_packet_len_o, // Length
  input wire logic pme_status_o, // Event status
  input wire logic pme_n_o // Event pin
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // Link edge that must be reported, and what it leaves behind
  sequence link_edge_s;
    $changed(link_up_i) && wake_filter_ctrl_i.link_change_en
      && !wake_status_reg_o.link_change_bit;
  endsequence
  sequence link_set_s;
    wake_status_reg_o.link_change_bit && pme_status_o;
  endsequence
  rx_commit_a: assert property (
    $rose(|wake_status_reg_o[3:0]) |-> $past(rx_valid_i && rx_byte_i.eof))
    else $error("rx status set away from frame end");
  rx_refuse_a: assert property (
    (|wake_status_reg_o[3:0]) && !(|status_clr_i[3:0])
      |=> $stable(wake_status_reg_o[3:0]) && $stable(wake_packet_len_o))
    else $error("packet taken while status pending");
  pin_set_a: assert property (
    $rose(pme_status_o) |-> (pme_n_o != $past(pme_en_i)))
    else $error("event pin wrong at status set");
  pin_hold_a: assert property (
    !pme_n_o && pme_en_i && !pme_status_w1c_i |=> !pme_n_o)
    else $error("event pin released early");
  pin_release_a: assert property (
    pme_status_w1c_i || !pme_en_i
      |=> pme_n_o || ($past(pme_en_i) && (wake_status_reg_o & ~$past(wake_status_reg_o)) != '0))
    else $error("event pin not released");
  status_hold_a: assert property (
    pme_status_o && !pme_status_w1c_i |=> pme_status_o)
    else $error("event status lost");
  link_wake_a: assert property (
    link_edge_s |-> ##[2:4] link_set_s)
    else $error("link change not reported");
  link_gate_a: assert property (
    $rose(wake_status_reg_o.link_change_bit)
      |-> $past(wake_filter_ctrl_i.link_change_en))
    else $error("link bit set while disabled");
  bcast_gate_a: assert property (
    $rose(wake_status_reg_o.broadcast_rx) |-> $past(wake_filter_ctrl_i.broadcast_wake_en))
    else $error("broadcast bit set while disabled");
endmodule

bind wpf_wakeup_filter wpf_wakeup_props u_props (.clk_i, .rst_n_i, .rx_valid_i, .rx_byte_i,
  .link_up_i, .wake_filter_ctrl_i, .pme_en_i, .pme_status_w1c_i, .status_clr_i,
  .wake_status_reg_o, .wake_packet_len_o, .pme_status_o, .pme_n_o);

// >>> wpf_host_model.sv
// Host power manager that services the event status bit
`timescale 1ns/100ps
module wpf_host_model (
  input wire logic clk_i, // Clock
  input wire logic pme_status_i, // Event status
  input wire logic ack_en_i, // Host allowed to service
  input wire logic [3:0] delay_i, // Service latency in cycles
  output logic w1c_o // Write one to status
);
  logic [3:0] cnt_reg = 4'h0;
  logic w1c_reg = 1'b0;
  assign w1c_o = w1c_reg;
  // release by status write; one pulse, guarded so it is not repeated
  always @(posedge clk_i) begin
    w1c_reg <= 1'b0;
    cnt_reg <= 4'h0;
    if (pme_status_i && ack_en_i && !w1c_reg) begin
      cnt_reg <= cnt_reg + 4'h1;
      if (cnt_reg == delay_i) begin
        w1c_reg <= 1'b1;
      end
    end
  end
endmodule

// >>> tb.sv
// Self-checking bench for the wakeup filter against a frame model
`timescale 1ns/100ps
module tb;
  import wpf_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic rx_valid_i = 1'b0;
  logic rx_good_i = 1'b1;
  logic addr_filter_pass_i = 1'b1;
  logic link_up_i = 1'b0;
  wpf_byte_s rx_byte_i = '0;
  wpf_filter_ctrl_s wake_filter_ctrl_i = '0;
  wpf_status_s status_clr_i = '0;
  wpf_status_s wake_status_reg_o;
  logic [767:0] rx_addr_i = '0;
  logic [15:0] rx_addr_valid_i = '0;
  logic [47:0] a0 = 48'h02a1b2c3d4e5;
  logic [47:0] rx_addr0_sw_i = '0;
  logic [47:0] nvm_addr0_i = '0;
  logic [47:0] rx_addr0_o;
  logic rx_addr0_wr_i = 1'b0;
  logic nvm_apm_en_i = 1'b0;
  logic nvm_load_i = 1'b0;
  logic pme_en_i = 1'b0;
  logic broadcast_accept_i = 1'b0;
  logic ack_en = 1'b0;
  logic pme_status_w1c_i, pme_status_o, pme_n_o, exp_pm;
  logic [3:0] dly = 4'h0;
  logic [6:0] mem_raddr_i = '0;
  logic [1:0] mo = 2'h0;
  logic [4095:0] mc_tab = '0;
  logic [7:0] mem_rdata_o;
  logic [13:0] wake_packet_len_o;
  logic [7:0] fq[$];
  logic [4:0] exp_st = '0;
  int exp_len = 0;
  int miscompares = 0;
  int checks_done = 0;

  always #12.5 clk_i = ~clk_i;

  // Design with the VLAN inputs tied off
  wpf_wakeup_filter dut (.clk_i, .rst_n_i, .rx_valid_i, .rx_byte_i, .rx_good_i,
    .addr_filter_pass_i, .link_up_i, .wake_filter_ctrl_i, .multicast_offset_sel_i(mo),
    .broadcast_accept_i, .vlan_mode_en_i(1'b0), .vlan_ethertype_i(16'h8100),
    .vlan_table_i('0), .mcast_table_i(mc_tab), .rx_addr_i, .rx_addr_valid_i, .rx_addr0_sw_i,
    .rx_addr0_wr_i, .nvm_addr0_i, .nvm_apm_en_i, .nvm_load_i, .pme_en_i, .pme_status_w1c_i,
    .status_clr_i, .mem_raddr_i, .mem_rdata_o, .wake_status_reg_o, .wake_packet_len_o,
    .pme_status_o, .pme_n_o, .rx_addr0_o);
  wpf_host_model host (.clk_i, .pme_status_i(pme_status_o), .ack_en_i(ack_en),
    .delay_i(dly), .w1c_o(pme_status_w1c_i));

  task chk(input logic [47:0] s, input logic [47:0] e);
    checks_done++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task end_of_test;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Random body bytes stop short of 0xff so no stray sync run forms
  task mk(input logic [47:0] da, input int n);
    fq = {};
    for (int i = 0; i < 6; i++) fq.push_back(da[47 - 8 * i -: 8]);
    for (int i = 6; i < n; i++) fq.push_back(8'($urandom_range(0, 254)));
  endtask

  task pat(input int at, input int ff);
    for (int j = 0; j < ff; j++) fq[at + j] = 8'hff;
    for (int k = 0; k < 96; k++) fq[at + ff + k] = a0[47 - 8 * (k % 6) -: 8];
  endtask

  // Send the queued frame, then predict and compare the outcome
  task frame(input logic good);
    logic [47:0] da;
    logic [4:0] hit;
    logic [11:0] mi;
    logic ok;
    int run;
    for (int i = 0; i < fq.size(); i++) begin
      @(posedge clk_i);
      rx_valid_i <= 1'b1;
      rx_byte_i <= {i == 0, i == fq.size() - 1, fq[i]};
      rx_good_i <= good;
    end
    @(posedge clk_i);
    rx_valid_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
    da = {fq[0], fq[1], fq[2], fq[3], fq[4], fq[5]};
    hit = '0;
    for (int i = 0; i < 16; i++)
      if (rx_addr_valid_i[i] && rx_addr_i[48 * i +: 48] == da) hit[0] = wake_filter_ctrl_i[0];
    hit[2] = wake_filter_ctrl_i.broadcast_wake_en && da == WPF_BCAST_ADDR;
    // Index is the last two address bytes rotated by the offset select
    mi = 12'({da[15:0], da[15:0]} >> (mo == 2'h3 ? 12 : 8 + int'(mo)));
    hit[1] = wake_filter_ctrl_i.multicast_wake_en && da[40] && mc_tab[mi];
    if (!addr_filter_pass_i) hit = '0;
    run = 0;
    for (int p = 0; p < fq.size(); p++) begin
      if (fq[p] == 8'hff) run++;
      else begin
        ok = run >= 6 && p + 96 <= fq.size();
        for (int k = 0; ok && k < 96; k++) ok = fq[p + k] == a0[47 - 8 * (k % 6) -: 8];
        if (ok && wake_filter_ctrl_i.pattern_en && (addr_filter_pass_i || hit[2] || da == '1))
          hit[3] = 1'b1;
        run = 0;
      end
    end
    if (good && exp_st[3:0] == 4'h0 && hit != 5'h0) begin
      exp_st = exp_st | hit;
      exp_len = fq.size();
      exp_pm = 1'b1;
    end
    chk(wake_status_reg_o, exp_st);
    chk(wake_packet_len_o, exp_len);
    chk({pme_status_o, pme_n_o}, {exp_pm, !(exp_pm && pme_en_i)});
  endtask

  task rd(input int a);
    @(posedge clk_i);
    mem_raddr_i <= 7'(a);
    repeat (2) @(posedge clk_i);
    #1 chk(mem_rdata_o, fq[a]);
  endtask

  // Host services at a random latency, prompt or slow
  task svc;
    @(posedge clk_i);
    ack_en <= 1'b1;
    dly <= 4'($urandom_range(0, 15));
    repeat (20) @(posedge clk_i);
    ack_en <= 1'b0;
    exp_pm = 1'b0;
    #1 chk({pme_status_o, pme_n_o}, 2'b01);
  endtask

  task clr;
    @(posedge clk_i);
    status_clr_i <= '1;
    @(posedge clk_i);
    status_clr_i <= '0;
    exp_st = '0;
  endtask

  task lnk;
    @(posedge clk_i);
    link_up_i <= !link_up_i;
    if (wake_filter_ctrl_i.link_change_en && !exp_st[4]) begin
      exp_st[4] = 1'b1;
      exp_pm = 1'b1;
    end
    repeat (6) @(posedge clk_i);
    #1 chk({wake_status_reg_o, pme_status_o}, {exp_st, exp_pm});
  endtask

  // Watchdog well beyond the expected few thousand cycles
  initial begin
    #(25 * 40000);
    miscompares++;
    end_of_test;
  end

  initial begin
    exp_pm = 1'b0;
    void'($urandom(30));
    for (int i = 0; i < 24; i++) rx_addr_i[32 * i +: 32] = $urandom;
    rx_addr_i[47:0] = a0;
    rx_addr_valid_i = 16'($urandom) | 16'h0021;
    rx_addr_valid_i[7] = 1'b0;
    broadcast_accept_i = 1'($urandom);
    repeat (20) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    // software write, then store load only when enabled
    rx_addr0_sw_i <= 48'h0a0b0c0d0e0f;
    rx_addr0_wr_i <= 1'b1;
    @(posedge clk_i);
    rx_addr0_wr_i <= 1'b0;
    nvm_addr0_i <= a0;
    nvm_load_i <= 1'b1;
    @(posedge clk_i);
    nvm_load_i <= 1'b0;
    #1 chk(rx_addr0_o, 48'h0a0b0c0d0e0f);
    @(posedge clk_i);
    nvm_apm_en_i <= 1'b1;
    nvm_load_i <= 1'b1;
    @(posedge clk_i);
    nvm_load_i <= 1'b0;
    @(posedge clk_i);
    #1 chk(rx_addr0_o, a0);
    $display("test address0 done");
    @(posedge clk_i);
    pme_en_i <= 1'b1;
    wake_filter_ctrl_i <= 5'h01;
    mk(WPF_BCAST_ADDR, 64);
    frame(1'b1);
    @(posedge clk_i);
    wake_filter_ctrl_i <= 5'h05;
    frame(1'b0);
    frame(1'b1);
    mk(rx_addr_i[48 * 5 +: 48], 60);
    frame(1'b1);
    svc;
    clr;
    frame(1'b1);
    svc;
    clr;
    mk(rx_addr_i[48 * 7 +: 48], 60);
    frame(1'b1);
    $display("test directed done");
    for (int pass = 0; pass < 2; pass++) begin
      @(posedge clk_i);
      wake_filter_ctrl_i <= 5'h0d;
      addr_filter_pass_i <= pass[0];
      pme_en_i <= pass[0];
      mk(WPF_BCAST_ADDR, 230);
      pat(20, 7);
      fq[40] = fq[40] ^ 8'h01;
      pat(123, 6);
      frame(1'b1);
      rd(0);
      rd(10);
      rd(127);
      svc;
      clr;
    end
    $display("test pattern done");
    // Multicast index under every offset select, hits and misses alike
    for (int m = 0; m < 8; m++) begin
      @(posedge clk_i);
      wake_filter_ctrl_i <= 5'h02;
      mo <= 2'(m);
      for (int i = 0; i < 128; i++) mc_tab[32 * i +: 32] <= $urandom;
      mk({8'($urandom) | 8'h01, 8'($urandom), 32'($urandom)}, 64);
      frame(1'b1);
      svc;
      clr;
    end
    $display("test multicast done");
    wake_filter_ctrl_i <= 5'h10;
    pme_en_i <= 1'b1;
    lnk;
    svc;
    lnk;
    clr;
    lnk;
    svc;
    clr;
    $display("test link done");
    end_of_test;
  end
endmodule
